// *** hw/ies_pkg.sv ***
// shared constants and types for the interrupt entry sequencer
`default_nettype none
package ies_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 16;                  // program counter width, words
  localparam int NSRC = 8;                   // interrupt sources, index 0 ranks first
  // boot section start, word address; plain default, variant dependent
  localparam logic [15:0] BOOT_START = 16'hf000;
  localparam logic [15:0] RESET_VEC_BASE = 16'h0000;
  // sources 0..3 keep a flag, 4..7 request on level only
  localparam logic [7:0] FLAG_TYPE_MASK = 8'h0f;
  // ----------------------------------------------------------------
  // register offsets, fields, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_FLAGS = 4'h0;   // cpu_flags_register
  localparam logic [3:0] OFF_ENABLE = 4'h1;  // per-source enables
  localparam logic [3:0] OFF_PEND = 4'h2;    // pending flags, write one to clear
  localparam logic [3:0] OFF_MCU_CONTROL_REGISTER = 4'h3;   // mcu_control_register
  localparam logic [3:0] OFF_STATUS = 4'h4;  // sequencer status, read only
  localparam int GIE_BIT = 7;
  localparam int RELOC_BIT = 1;              // vector_relocate_bit position
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  // ----------------------------------------------------------------
  // timing counts, in core clock cycles, and return address bytes
  // ----------------------------------------------------------------
  localparam logic [2:0] ENTRY_CYCLES = 3'h5;
  localparam logic [2:0] WAKE_CYCLES = 3'h5;
  localparam logic [2:0] RETURN_CYCLES = 3'h5;
  localparam logic [2:0] PC_BYTES = 3'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_RUN, PH_WAKE, PH_ENTRY, PH_RETURN} ies_phase_t;
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR} ies_alu_op_t;
  typedef struct packed {
    logic wr; logic rd; logic [3:0] addr; logic [7:0] wdata;
  } ies_bus_t;
  typedef struct packed {
    logic done; logic is_sei; logic is_cli; logic is_return_from_irq_instr;
  } ies_step_t;
  typedef struct packed {
    logic go; ies_alu_op_t op; logic [7:0] a; logic [7:0] b;
  } ies_alu_req_t;
  typedef struct packed {
    logic push; logic pop; logic [7:0] data;
  } ies_stack_t;
  typedef struct packed {
    ies_phase_t phase; logic [2:0] count; logic gie; logic [6:0] flags_low;
    logic [7:0] enable; logic [7:0] pend; logic relocate; logic post_ret;
    logic [2:0] last_idx; logic [15:0] vec_pc; logic vec_valid; logic hold;
    ies_stack_t stack; logic [15:0] saved_pc; logic [7:0] rdata;
    logic [7:0] alu_result; logic alu_wb; logic [15:0] reset_vec;
  } ies_state_t;
endpackage
`default_nettype wire

// *** hw/ies_sequencer.sv ***
// reset and interrupt entry sequencer for the 8-bit core
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

// ------------------------------------------------------------------
// module
// ------------------------------------------------------------------
// Contract
// [RQ1] core clock undivided from chip source
// [RQ2] two-operand alu result written in one cycle
// [RQ3] separate vectors; own and global enable
// [RQ4] boot lock bits suppress by pc
// [RQ5] lower vector address wins, reset first
// [RQ6] relocate bit moves vectors to boot
// [RQ7] boot reset fuse moves reset vector
// [RQ8] entry clears global enable, nesting allowed
// [RQ9] return instruction sets global enable
// [RQ10] vectoring clears flag-type source flag
// [RQ11] write one clears flag, zero keeps
// [RQ12] disabled flags stay pending, priority served
// [RQ13] level sources request only while present
// [RQ14] one instruction runs after return
// [RQ15] flags register never saved or restored
// [RQ16] disable instruction blocks same-cycle interrupt
// [RQ17] instruction after enable runs first
// [RQ18] entry five cycles, pushing program counter
// [RQ19] multi-cycle instruction completes before entry
// [RQ20] wake from sleep adds five cycles
// [RQ21] return five cycles, pops three bytes
// [RQ22] program counter sixteen bits, word addressed
// [RQ23] global enable is flags bit seven
module ies_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire ies_pkg::ies_bus_t bus_in,
  output var logic [7:0] rd_data,
  // core program flow
  input wire ies_pkg::ies_step_t step,
  input wire logic [15:0] pc_now,
  input wire logic sleeping,
  output var logic core_hold,
  output var logic vec_valid,
  output var logic [15:0] vec_pc,
  output var ies_pkg::ies_stack_t stack,
  output var logic global_enable,
  output var logic [15:0] reset_vector,
  // single-cycle alu path
  input wire ies_pkg::ies_alu_req_t alu_req,
  output var logic [7:0] alu_result,
  output var logic alu_wb,
  // interrupt sources
  input wire logic [7:0] src_event,
  input wire logic [7:0] src_level,
  // fuses and lock bits
  input wire logic boot_reset_fuse,
  input wire logic boot_lock_app_bit,
  input wire logic boot_lock_boot_bit
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // priority pick: lowest index first, {any, index}
  function automatic logic [3:0] first_req(input logic [7:0] r);
    logic [3:0] res;
    res = 4'h0;
    for (int i = ies_pkg::NSRC - 1; i >= 0; i--) begin
      if (r[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  // vector word address; slot 0 belongs to reset, two words per slot
  function automatic logic [15:0] vector_of(input logic reloc, input logic [2:0] idx);
    logic [15:0] slot;
    logic [15:0] base;
    slot = {13'h0000, idx} + 16'h0001;
    base = reloc ? ies_pkg::BOOT_START : ies_pkg::RESET_VEC_BASE;
    return base + {slot[14:0], 1'b0};
  endfunction

  // boot lock suppression by section of the current program counter
  function automatic logic is_locked(input logic [15:0] pc, input logic app,
                                     input logic boot);
    return (app && (pc < ies_pkg::BOOT_START)) || (boot && (pc >= ies_pkg::BOOT_START));
  endfunction

  // byte of the return address; third byte is zero for a 16-bit counter
  function automatic logic [7:0] pc_byte(input logic [15:0] pc, input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == 3'h0) begin
      b = pc[7:0];
    end else if (idx == 3'h1) begin
      b = pc[15:8];
    end
    return b;
  endfunction

  // alu arithmetic on two register operands
  function automatic logic [7:0] alu_calc(input ies_pkg::ies_alu_op_t op,
                                          input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    unique case (op)
      ies_pkg::ALU_ADD: r = 8'(a + b);
      ies_pkg::ALU_SUB: r = 8'(a - b);
      ies_pkg::ALU_AND: r = a & b;
      ies_pkg::ALU_OR: r = a | b;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state and request decode
  // ----------------------------------------------------------------
  ies_pkg::ies_state_t st;       // every flop of the block
  ies_pkg::ies_state_t next_st;  // value for the next edge
  logic [7:0] req;               // enabled requests this cycle
  logic [3:0] pick;              // {any, index} of the winner
  logic [2:0] take_idx;          // winning source
  logic boundary;                // a legal point to enter
  logic take_now;                // entry starts this edge
  logic [7:0] w1c_mask;          // bits a flag write really clears

  // [RQ12] [RQ13] latched flags plus live levels, gated by own enables
  assign req = ((st.pend & ies_pkg::FLAG_TYPE_MASK) |
                (src_level & ~ies_pkg::FLAG_TYPE_MASK)) & st.enable;
  // [RQ5] lowest index wins
  assign pick = first_req(req);
  assign take_idx = pick[2:0];
  assign w1c_mask = bus_in.wdata & ~src_event & ies_pkg::FLAG_TYPE_MASK;

  // [RQ19] at an instruction end or while sleeping; [RQ16] [RQ17] not after cli, sei or return
  // [RQ14] a sleeping core right after return is not a boundary yet
  assign boundary = (step.done && !step.is_cli && !step.is_sei && !step.is_return_from_irq_instr) ||
                    (sleeping && !st.post_ret && !step.done);
  // [RQ3] [RQ4] global enable, own enable and boot lock all agree
  assign take_now = (st.phase == ies_pkg::PH_RUN) && boundary && st.gie && pick[3] &&
                    !is_locked(pc_now, boot_lock_app_bit, boot_lock_boot_bit);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // one process computes every flop; pulses default low each cycle
  always_comb begin
    next_st = st;
    next_st.vec_valid = 1'b0;
    next_st.stack = '0;
    next_st.rdata = 8'h00;
    // [RQ7] reset vector follows the fuse
    next_st.reset_vec = boot_reset_fuse ? ies_pkg::BOOT_START : ies_pkg::RESET_VEC_BASE;

    // [RQ2] result and write-back strobe land together one edge later
    next_st.alu_wb = alu_req.go;
    if (alu_req.go) begin
      next_st.alu_result = alu_calc(alu_req.op, alu_req.a, alu_req.b);
    end

    // register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        ies_pkg::OFF_FLAGS: begin
          // [RQ23] global enable is bit seven, others plain storage
          next_st.gie = bus_in.wdata[ies_pkg::GIE_BIT];
          next_st.flags_low = bus_in.wdata[6:0];
        end
        ies_pkg::OFF_ENABLE: begin
          next_st.enable = bus_in.wdata;
        end
        ies_pkg::OFF_PEND: begin
          // [RQ11] ones clear, zeros keep
          next_st.pend = st.pend & ~(bus_in.wdata & ies_pkg::FLAG_TYPE_MASK);
        end
        ies_pkg::OFF_MCU_CONTROL_REGISTER: begin
          // [RQ6] relocation of all interrupt vectors
          next_st.relocate = bus_in.wdata[ies_pkg::RELOC_BIT];
        end
        default: begin
          // status and unmapped offsets ignore writes
        end
      endcase
    end

    // register reads; data shows only in the cycle after the strobe
    if (bus_in.rd) begin
      case (bus_in.addr)
        ies_pkg::OFF_FLAGS: next_st.rdata = {st.gie, st.flags_low};
        ies_pkg::OFF_ENABLE: next_st.rdata = st.enable;
        ies_pkg::OFF_PEND: next_st.rdata = st.pend | (src_level & ~ies_pkg::FLAG_TYPE_MASK);
        ies_pkg::OFF_STATUS: next_st.rdata = {st.hold, st.post_ret, st.gie, 2'b00, st.last_idx};
        ies_pkg::OFF_MCU_CONTROL_REGISTER: next_st.rdata = {6'h00, st.relocate, 1'b0};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // instruction side effects on the global enable
    if (step.done && (st.phase == ies_pkg::PH_RUN)) begin
      // [RQ16] cli clears at once
      if (step.is_cli) begin
        next_st.gie = 1'b0;
      end
      // [RQ17] sei sets, but this boundary is skipped
      if (step.is_sei) begin
        next_st.gie = 1'b1;
      end
      // [RQ14] the first instruction after return has now run
      next_st.post_ret = 1'b0;
    end

    // sequencer phases
    unique case (st.phase)
      ies_pkg::PH_RUN: begin
        if (take_now) begin
          // [RQ8] block everything until software or return re-enables
          next_st.gie = 1'b0;
          next_st.last_idx = take_idx;
          next_st.saved_pc = pc_now;
          next_st.vec_pc = vector_of(st.relocate, take_idx);
          next_st.count = 3'h0;
          // [RQ10] hardware clears the served flag
          if (ies_pkg::FLAG_TYPE_MASK[take_idx]) begin
            next_st.pend[take_idx] = 1'b0;
          end
          if (sleeping && !step.done) begin
            // [RQ20] wake path inserts extra cycles first
            next_st.phase = ies_pkg::PH_WAKE;
          end else begin
            // [RQ18] entry begins with the low return byte
            next_st.phase = ies_pkg::PH_ENTRY;
            next_st.stack.push = 1'b1;
            next_st.stack.data = pc_byte(pc_now, 3'h0);
          end
        end else if (step.done && step.is_return_from_irq_instr) begin
          // [RQ21] return pops the first byte right away
          next_st.phase = ies_pkg::PH_RETURN;
          next_st.count = 3'h0;
          next_st.stack.pop = 1'b1;
        end
      end
      ies_pkg::PH_WAKE: begin
        // [RQ20] five wake cycles, then normal entry
        if (st.count == 3'(ies_pkg::WAKE_CYCLES - 3'h1)) begin
          next_st.phase = ies_pkg::PH_ENTRY;
          next_st.count = 3'h0;
          next_st.stack.push = 1'b1;
          next_st.stack.data = pc_byte(st.saved_pc, 3'h0);
        end else begin
          next_st.count = 3'(st.count + 3'h1);
        end
      end
      ies_pkg::PH_ENTRY: begin
        // [RQ18] five cycles, three bytes pushed, then vector issued
        if (st.count == 3'(ies_pkg::ENTRY_CYCLES - 3'h1)) begin
          next_st.phase = ies_pkg::PH_RUN;
          next_st.vec_valid = 1'b1;
        end else begin
          next_st.count = 3'(st.count + 3'h1);
          if (3'(st.count + 3'h1) < ies_pkg::PC_BYTES) begin
            next_st.stack.push = 1'b1;
            next_st.stack.data = pc_byte(st.saved_pc, 3'(st.count + 3'h1));
          end
        end
      end
      ies_pkg::PH_RETURN: begin
        // [RQ21] three pops in five cycles, enable set at the end
        if (st.count == 3'(ies_pkg::RETURN_CYCLES - 3'h1)) begin
          next_st.phase = ies_pkg::PH_RUN;
          // [RQ9] return always re-enables
          next_st.gie = 1'b1;
          next_st.post_ret = 1'b1;
        end else begin
          next_st.count = 3'(st.count + 3'h1);
          next_st.stack.pop = 3'(st.count + 3'h1) < ies_pkg::PC_BYTES;
        end
      end
    endcase

    // [RQ12] a new event beats any clear in the same cycle
    next_st.pend = next_st.pend | (src_event & ies_pkg::FLAG_TYPE_MASK);
    // core is held whenever the sequencer owns program flow
    next_st.hold = next_st.phase != ies_pkg::PH_RUN;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // [RQ1] everything on the one undivided core clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.phase <= ies_pkg::PH_RUN;
      st.gie <= ies_pkg::FLAGS_RST[ies_pkg::GIE_BIT];
      st.flags_low <= ies_pkg::FLAGS_RST[6:0];
      st.enable <= ies_pkg::ENABLE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops
  // ----------------------------------------------------------------
  // [RQ15] entry and return never push or pop the flags register; they only clear or set its bit seven
  assign rd_data = st.rdata;
  assign core_hold = st.hold;
  assign vec_valid = st.vec_valid;
  // [RQ22] sixteen-bit word address
  assign vec_pc = st.vec_pc;
  assign stack = st.stack;
  assign global_enable = st.gie;
  assign reset_vector = st.reset_vec;
  assign alu_result = st.alu_result;
  assign alu_wb = st.alu_wb;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_entry_length: assert property (@(posedge clk) disable iff (!reset_n) // [RQ18]
    (take_now && !(sleeping && !step.done)) |=> st.hold [*5] ##1 (st.vec_valid && !st.hold))
    else $error("entry did not take five cycles");
  a_entry_pushes: assert property (@(posedge clk) disable iff (!reset_n) // [RQ18]
    (take_now && !(sleeping && !step.done)) |=> st.stack.push [*3] ##1 !st.stack.push)
    else $error("entry did not push three bytes");
  a_wake_extra: assert property (@(posedge clk) disable iff (!reset_n) // [RQ20]
    (take_now && sleeping && !step.done) |=> (st.phase == ies_pkg::PH_WAKE) [*5]
    ##1 (st.phase == ies_pkg::PH_ENTRY) [*5] ##1 st.vec_valid)
    else $error("wake entry not five plus five cycles");
  a_entry_gie_off: assert property (@(posedge clk) disable iff (!reset_n) // [RQ8]
    take_now |=> !st.gie && st.hold)
    else $error("global enable not cleared on entry");
  a_return_length: assert property (@(posedge clk) disable iff (!reset_n) // [RQ21]
    (st.phase == ies_pkg::PH_RUN && !take_now && step.done && step.is_return_from_irq_instr)
    |=> (st.hold && !st.gie) [*5] ##1 (st.gie && !st.hold))
    else $error("return not five cycles or enable not set");
  a_cli_blocks: assert property (@(posedge clk) disable iff (!reset_n) // [RQ16]
    (step.done && step.is_cli && st.phase == ies_pkg::PH_RUN)
    |=> !st.gie && (st.phase != ies_pkg::PH_ENTRY) && (st.phase != ies_pkg::PH_WAKE))
    else $error("interrupt taken with cli");
  a_sei_defers: assert property (@(posedge clk) disable iff (!reset_n) // [RQ17]
    (step.done && step.is_sei && st.phase == ies_pkg::PH_RUN)
    |=> st.gie && (st.phase == ies_pkg::PH_RUN))
    else $error("interrupt taken right after sei");
  a_hw_flag_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RQ10]
    (take_now && ies_pkg::FLAG_TYPE_MASK[take_idx] && !src_event[take_idx])
    |=> !st.pend[$past(take_idx)])
    else $error("served flag not cleared");
  a_w1c_clears: assert property (@(posedge clk) disable iff (!reset_n) // [RQ11]
    (bus_in.wr && bus_in.addr == ies_pkg::OFF_PEND) |=> (st.pend & $past(w1c_mask)) == 8'h00)
    else $error("write one did not clear flag");
  a_priority_low: assert property (@(posedge clk) disable iff (!reset_n) // [RQ5]
    take_now |-> (req & 8'((8'h01 << take_idx) - 8'h01)) == 8'h00)
    else $error("lower index request was skipped");
  a_level_live: assert property (@(posedge clk) disable iff (!reset_n) // [RQ13]
    (take_now && !ies_pkg::FLAG_TYPE_MASK[take_idx]) |-> src_level[take_idx])
    else $error("level source served without its level");
  a_lock_blocks: assert property (@(posedge clk) disable iff (!reset_n) // [RQ4]
    is_locked(pc_now, boot_lock_app_bit, boot_lock_boot_bit) |-> !take_now)
    else $error("interrupt taken under boot lock");
  a_vector_relocated: assert property (@(posedge clk) disable iff (!reset_n) // [RQ6]
    (take_now && st.relocate) |=> st.vec_pc >= ies_pkg::BOOT_START)
    else $error("vector not relocated to boot section");
  a_alu_single: assert property (@(posedge clk) disable iff (!reset_n) // [RQ2]
    alu_req.go |=> st.alu_wb && (st.alu_result == $past(alu_calc(alu_req.op, alu_req.a,
    alu_req.b))))
    else $error("alu result not written in one cycle");

endmodule
`default_nettype wire

// *** verif/ies_core_model.sv ***
// behavioural core program flow that feeds the sequencer its instruction boundaries
`default_nettype none
module ies_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench commands
  input wire logic issue,
  input wire logic [1:0] cmd,
  // sequencer answers
  input wire logic core_hold,
  input wire logic vec_valid,
  input wire logic [15:0] vec_pc,
  // program flow towards sequencer
  output var ies_pkg::ies_step_t step,
  output var logic [15:0] pc_now
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // boundary decode
  // ----------------------------------------------------------------
  // no boundary while the sequencer owns flow, like a stalled pipe
  always_comb begin
    step = '0;
    step.done = issue & ~core_hold;
    step.is_sei = step.done & (cmd == 2'h1);
    step.is_cli = step.done & (cmd == 2'h2);
    step.is_return_from_irq_instr = step.done & (cmd == 2'h3);
  end
  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // jump on vector, else one word per instruction; return not restored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_now <= 16'h0000;
    end else if (vec_valid) begin
      pc_now <= vec_pc;
    end else if (step.done) begin
      pc_now <= pc_now + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the interrupt entry sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ies_pkg::ies_bus_t bus_in = '0;
  ies_pkg::ies_step_t step;
  ies_pkg::ies_stack_t stack;
  ies_pkg::ies_alu_req_t alu_req = '0;
  logic [7:0] rd_data, alu_result, src_event = 8'h00, src_level = 8'h00;
  logic [15:0] pc_now, vec_pc, reset_vector, pc0;
  logic core_hold, vec_valid, global_enable, alu_wb;
  logic issue = 1'b0, sleeping = 1'b0, lock_app = 1'b0, lock_boot = 1'b0, fuse = 1'b1;
  logic [1:0] cmd = 2'h0;
  logic [31:0] r;
  logic [7:0] bytes [3];
  int error_cnt = 0, total_checks = 0, hcnt, pcnt, ocnt, vat, seed = 82576;
  // 20 ns core clock
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  ies_sequencer dut (.clk(clk), .reset_n(reset_n), .bus_in(bus_in), .rd_data(rd_data),
    .step(step), .pc_now(pc_now), .sleeping(sleeping), .core_hold(core_hold),
    .vec_valid(vec_valid), .vec_pc(vec_pc), .stack(stack), .global_enable(global_enable),
    .reset_vector(reset_vector), .alu_req(alu_req), .alu_result(alu_result),
    .alu_wb(alu_wb), .src_event(src_event), .src_level(src_level),
    .boot_reset_fuse(fuse), .boot_lock_app_bit(lock_app), .boot_lock_boot_bit(lock_boot));
  ies_core_model core (.clk(clk), .reset_n(reset_n), .issue(issue), .cmd(cmd),
    .core_hold(core_hold), .vec_valid(vec_valid), .vec_pc(vec_pc), .step(step),
    .pc_now(pc_now));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] alu_exp(input logic [1:0] op, input logic [7:0] a,
                                         input logic [7:0] b);
    case (op)
      2'h0: return a + b;
      2'h1: return a - b;
      2'h2: return a & b;
      default: return a | b;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one-cycle write strobe; return at the strobe's release edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_in <= '0;
  endtask
  // read data only stands in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_in <= '0;
    @(negedge clk);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask
  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= 8'h00;
  endtask
  // tally flow outputs cycle by cycle after a boundary
  task automatic watch(input int n);
    hcnt = 0;
    pcnt = 0;
    ocnt = 0;
    vat = 0;
    for (int i = 1; i <= n; i++) begin
      @(negedge clk);
      if (core_hold === 1'b1) hcnt++;
      if (stack.pop === 1'b1) ocnt++;
      if (vec_valid === 1'b1) vat = i;
      if (stack.push === 1'b1 && pcnt < 3) begin
        bytes[pcnt] = stack.data;
        pcnt++;
      end
    end
  endtask
  task automatic instr(input logic [1:0] c, input int n);
    @(posedge clk);
    issue <= 1'b1;
    cmd <= c;
    @(posedge clk);
    issue <= 1'b0;
    watch(n);
  endtask
  task automatic snooze(input int n);
    @(posedge clk);
    sleeping <= 1'b1;
    @(posedge clk);
    sleeping <= 1'b0;
    watch(n);
  endtask
  task automatic entry_chk(input logic [15:0] v, input logic [15:0] pc, input int h);
    chk(16'(hcnt), 16'(h));
    chk(16'(vat), 16'(h + 1));
    chk(16'(pcnt), 16'h0003);
    chk(vec_pc, v);
    chk({bytes[1], bytes[0]}, pc);
    chk({8'h00, bytes[2]}, 16'h0000);
    chk({15'h0000, global_enable}, 16'h0000);
  endtask
  task automatic quiet(input logic g);
    chk(16'(hcnt), 16'h0000);
    chk({15'h0000, global_enable}, {15'h0000, g});
  endtask
  task automatic leave();
    instr(2'h3, 8);
    chk(16'(hcnt), 16'h0005);
    chk(16'(ocnt), 16'h0003);
    chk({15'h0000, global_enable}, 16'h0001);
  endtask
  // ----------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // the reset vector is a flop: look after the edge that loads it
    @(negedge clk);
    chk(reset_vector, ies_pkg::BOOT_START);
    @(posedge clk);
    fuse <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(reset_vector, ies_pkg::RESET_VEC_BASE);
    rdc(4'h1, 8'h00);
    rdc(4'hf, 8'h00);
    wr(4'h0, 8'h85);
    rdc(4'h0, 8'h85);
    fire(8'h05);
    instr(2'h0, 8);
    quiet(1'b1);
    rdc(4'h2, 8'h05);
    wr(4'h2, 8'h01);
    rdc(4'h2, 8'h04);
    fire(8'h01);
    wr(4'h1, 8'h05);
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(16'h0002, pc0, 5);
    rdc(4'h2, 8'h04);
    rdc(4'h0, 8'h05);
    leave();
    rdc(4'h0, 8'h85);
    snooze(4);
    quiet(1'b1);
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(16'h0006, pc0, 5);
    leave();
    wr(4'h3, 8'h02);
    fire(8'h08);
    wr(4'h1, 8'h08);
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(ies_pkg::BOOT_START + 16'h0008, pc0, 5);
    leave();
    wr(4'h3, 8'h00);
    fire(8'h01);
    wr(4'h1, 8'h01);
    instr(2'h2, 4);
    quiet(1'b0);
    instr(2'h1, 4);
    quiet(1'b1);
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(16'h0002, pc0, 5);
    leave();
    instr(2'h0, 2);
    fire(8'h01);
    pc0 = pc_now;
    snooze(13);
    entry_chk(16'h0002, pc0, 10);
    leave();
    // level source that vanishes before it is enabled
    wr(4'h1, 8'h00);
    @(posedge clk);
    src_level <= 8'h10;
    @(posedge clk);
    src_level <= 8'h00;
    wr(4'h1, 8'h10);
    instr(2'h0, 8);
    quiet(1'b1);
    @(posedge clk);
    src_level <= 8'h10;
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(16'h000a, pc0, 5);
    @(posedge clk);
    src_level <= 8'h00;
    leave();
    // application lock while running below the boot section
    @(posedge clk);
    lock_app <= 1'b1;
    fire(8'h01);
    wr(4'h1, 8'h01);
    instr(2'h0, 8);
    quiet(1'b1);
    // boot-section lock must not block code running below the boot section
    @(posedge clk);
    lock_app <= 1'b0;
    lock_boot <= 1'b1;
    pc0 = pc_now;
    instr(2'h0, 8);
    entry_chk(16'h0002, pc0, 5);
    leave();
    // status: not held, return just done, enable set, last source 0
    rdc(4'h4, 8'h60);
    // random alu traffic, first one a subtract of 01 from ff
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      if (i == 0) r = 32'h0001_ff01;
      @(posedge clk);
      alu_req <= '{go: 1'b1, op: ies_pkg::ies_alu_op_t'(r[1:0]), a: r[15:8], b: r[23:16]};
      @(posedge clk);
      alu_req <= '0;
      @(negedge clk);
      chk({7'h00, alu_wb, alu_result}, {8'h01, alu_exp(r[1:0], r[15:8], r[23:16])});
    end
    close_out();
  end
endmodule
`default_nettype wire
